// [design/angle_linearizer.sv]
/*
  Piecewise-linear angle correction with 32 breakpoints, its power-up load
  from non-volatile storage, and the unlinearized low-power wake tracker.
  Assumes raw angle, storage data and mode inputs come from logic on clk;
  storage answers the cycle after a read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alin_defs.svh"

module angle_linearizer #(
  parameter logic [`ALIN_WIN_W-1:0] WAKE_WIN_CYC = `ALIN_WIN_W'(`ALIN_WAKE_WIN_CYC)
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,

  // raw electrical angle from the angle path
  input  wire logic [`ALIN_ANG_W-1:0]     rawAngle,
  input  wire logic                       rawValid,

  // non-volatile storage read port
  output logic                            nvmRdEn,
  output logic      [`ALIN_NVM_AW-1:0]    nvmAddr,
  input  wire logic [`ALIN_NVM_DW-1:0]    nvmData,

  // linearized angle toward the output formatters
  output logic      [`ALIN_ANG_W-1:0]     linAngle,
  output logic                            linValid,

  // configuration and status
  output logic                            cfgReady,
  output logic                            linEnable,
  output logic                            correctionScaleSelect,

  // low-power tracking
  input  wire logic                       lowPower,
  input  wire logic [`ALIN_ANG_W-1:0]     wakeThresh,
  output logic      [`ALIN_ANG_W-1:0]     trackAngle,
  output logic                            wakeReq,

  // coefficient readback as user data
  input  wire logic [`ALIN_IDX_W-1:0]     userAddr,
  output logic      [`ALIN_COEF_W-1:0]    userData
);

  alin_pkg::alin_state_s q;
  alin_pkg::alin_state_s n;

  logic [`ALIN_COEF_W-1:0] interpCorr;
  logic [`ALIN_ANG_W-1:0]  corrExt;
  logic [`ALIN_ANG_W-1:0]  delta;

  // magnitude of the shortest angular distance on the circle
  function automatic logic [`ALIN_ANG_W-1:0] angDist(
    input logic [`ALIN_ANG_W-1:0] a,
    input logic [`ALIN_ANG_W-1:0] b
  );
    logic [`ALIN_ANG_W-1:0] d;
    d = a - b;
    if (d[`ALIN_ANG_W-1]) begin
      d = (~d) + `ALIN_ANG_W'(1);
    end
    return d;
  endfunction

  // one coefficient LSB is one angle LSB; scale select doubles it
  function automatic logic [`ALIN_ANG_W-1:0] scaleCorr(
    input logic [`ALIN_COEF_W-1:0] c,
    input logic                    s
  );
    logic [`ALIN_ANG_W-1:0] e;
    e = {{(`ALIN_ANG_W-`ALIN_COEF_W){c[`ALIN_COEF_W-1]}}, c};
    if (s) begin
      e = {e[`ALIN_ANG_W-2:0], 1'b0};
    end
    return e;
  endfunction

  alin_interp u_interp (
    .coefLo (q.p1C0),
    .coefHi (q.p1C1),
    .frac   (q.p1Frac),
    .corr   (interpCorr)
  );

  always_comb begin
    n = q;
    n.nvmRdEn  = 1'b0;
    n.linValid = 1'b0;
    n.wakeReq  = 1'b0;
    corrExt    = scaleCorr(q.p2Corr, q.p2Scale);
    delta      = angDist(q.trackAngle, q.lastAngle);

    // storage answer lands one cycle after the strobe
    n.capValid = q.nvmRdEn;
    n.capAddr  = q.nvmAddr;
    if (q.capValid) begin
      if (q.capAddr == `ALIN_NVM_CFG_ADDR) begin
        n.linEn    = nvmData[`ALIN_CFG_EN_BIT];
        n.scaleSel = nvmData[`ALIN_CFG_SCALE_BIT];
      end else begin
        n.coef[q.capAddr[`ALIN_IDX_W-1:0]] = nvmData;
      end
    end

    // load sequencer: 32 coefficients then the configuration word
    case (q.state)
      alin_pkg::ST_LOAD: begin
        n.nvmRdEn = 1'b1;
        n.nvmAddr = q.ldAddr;
        if (q.ldAddr == `ALIN_NVM_CFG_ADDR) begin
          n.state = alin_pkg::ST_DRAIN;
        end else begin
          n.ldAddr = q.ldAddr + `ALIN_NVM_AW'(1);
        end
      end
      alin_pkg::ST_DRAIN: begin
        if (!q.nvmRdEn && !q.capValid) begin
          n.state    = alin_pkg::ST_RUN;
          n.cfgReady = 1'b1;
        end
      end
      alin_pkg::ST_RUN: begin
        n.cfgReady = 1'b1;
      end
      default: begin
        n.state = alin_pkg::ST_LOAD;
      end
    endcase

    // stage 1: pick the breakpoint pair; index wraps 31 to 0 at the top
    n.p1Valid = 1'b0;
    if (q.state == alin_pkg::ST_RUN && rawValid) begin
      n.p1Valid = 1'b1;
      n.p1Raw   = rawAngle;
      n.p1C0    = q.coef[rawAngle[`ALIN_ANG_W-1:`ALIN_FRAC_W]];
      n.p1C1    = q.coef[rawAngle[`ALIN_ANG_W-1:`ALIN_FRAC_W] + `ALIN_IDX_W'(1)];
      n.p1Frac  = rawAngle[`ALIN_FRAC_W-1:0];
      // settings travel with the sample so a mode change never splits one
      n.p1En    = q.linEn;
      n.p1Scale = q.scaleSel;
    end

    // stage 2: interpolated correction
    n.p2Valid = q.p1Valid;
    n.p2Raw   = q.p1Raw;
    n.p2Corr  = interpCorr;
    n.p2En    = q.p1En;
    n.p2Scale = q.p1Scale;

    // stage 3: both settings leave from the same flop, same depth
    if (q.p2Valid) begin
      n.linValid = 1'b1;
      if (q.p2En) begin
        n.linAngle = q.p2Raw - corrExt;
      end else begin
        n.linAngle = q.p2Raw;
      end
    end

    // unlinearized tracking for the low-power wake decision
    if (q.state == alin_pkg::ST_RUN && rawValid) begin
      n.trackAngle = rawAngle;
    end
    if (!lowPower) begin
      n.winCnt    = '0;
      n.lastAngle = q.trackAngle;
    end else if (q.winCnt >= WAKE_WIN_CYC - `ALIN_WIN_W'(1)) begin
      n.winCnt    = '0;
      n.lastAngle = q.trackAngle;
      // rate test: change per window against the programmed limit
      if (delta > wakeThresh) begin
        n.wakeReq = 1'b1;
      end
    end else begin
      n.winCnt = q.winCnt + `ALIN_WIN_W'(1);
    end

    // coefficients stay readable whether or not they are applied
    n.userData = q.coef[userAddr];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q.state      <= alin_pkg::ST_LOAD;
      q.ldAddr     <= `ALIN_NVM_ADDR_RST;
      q.nvmRdEn    <= 1'b0;
      q.nvmAddr    <= `ALIN_NVM_ADDR_RST;
      q.capValid   <= 1'b0;
      q.capAddr    <= `ALIN_NVM_ADDR_RST;
      q.coef       <= '0;
      q.linEn      <= 1'b0;
      q.scaleSel   <= 1'b0;
      q.cfgReady   <= 1'b0;
      q.p1Valid    <= 1'b0;
      q.p1Raw      <= `ALIN_ANG_RST;
      q.p1C0       <= `ALIN_COEF_RST;
      q.p1C1       <= `ALIN_COEF_RST;
      q.p1Frac     <= '0;
      q.p1En       <= 1'b0;
      q.p1Scale    <= 1'b0;
      q.p2Valid    <= 1'b0;
      q.p2Raw      <= `ALIN_ANG_RST;
      q.p2Corr     <= `ALIN_COEF_RST;
      q.p2En       <= 1'b0;
      q.p2Scale    <= 1'b0;
      q.linValid   <= 1'b0;
      q.linAngle   <= `ALIN_ANG_RST;
      q.trackAngle <= `ALIN_ANG_RST;
      q.lastAngle  <= `ALIN_ANG_RST;
      q.winCnt     <= '0;
      q.wakeReq    <= 1'b0;
      q.userData   <= `ALIN_COEF_RST;
    end else begin
      q <= n;
    end
  end

  assign nvmRdEn               = q.nvmRdEn;
  assign nvmAddr               = q.nvmAddr;
  assign linAngle              = q.linAngle;
  assign linValid              = q.linValid;
  assign cfgReady              = q.cfgReady;
  assign linEnable             = q.linEn;
  assign correctionScaleSelect = q.scaleSel;
  assign trackAngle            = q.trackAngle;
  assign wakeReq               = q.wakeReq;
  assign userData              = q.userData;

endmodule

`default_nettype wire

// [shared/alin_defs.svh]
/*
  Constants of the angle linearizer: widths, storage map, reset values and
  the wake-window timing. Assumes a 20 MHz processing clock.
*/
// Overview of operation
// - Thirty-two correction coefficients are held, one per 11.25 degree breakpoint from 0.00 to 348.75 degrees.
// - At a breakpoint the output is the electrical angle minus that breakpoint's coefficient.
// - Each coefficient is a 12-bit two's-complement value from -2048 to +2047.
// - Scale select clear gives about +22.50..-22.49 degrees of correction, set doubles it, negative codes add angle.
// - Between breakpoints the correction is linearly interpolated from the two neighbouring coefficients.
// - The output latency is the same whether linearization is on or off.
// - With linearization off the stored coefficients have no effect on the output angle.
// - The low-power tracking path and its wake decision use the unlinearized electrical angle.
// - In low power the block requests wake when the angle changes faster than a programmable rate.
// - The corrected angle is the mechanical angle fed to the downstream angle outputs.
// - After reset all coefficients and settings are reloaded from storage before any angle is produced.
`ifndef ALIN_DEFS_SVH
`define ALIN_DEFS_SVH

`define ALIN_ANG_W          15
`define ALIN_NUM_PTS        32
`define ALIN_IDX_W          5
`define ALIN_FRAC_W         10
`define ALIN_COEF_W         12
`define ALIN_NVM_AW         6
`define ALIN_NVM_DW         12
`define ALIN_NVM_LAST_COEF  6'h1F
`define ALIN_NVM_CFG_ADDR   6'h20
`define ALIN_CFG_EN_BIT     0
`define ALIN_CFG_SCALE_BIT  1

`define ALIN_COEF_RST       12'h000
`define ALIN_ANG_RST        15'h0000
`define ALIN_NVM_ADDR_RST   6'h00

`define ALIN_CLK_PERIOD_NS  50
`define ALIN_WAKE_WIN_US    1000
`define ALIN_WAKE_WIN_CYC   (`ALIN_WAKE_WIN_US * 1000 / `ALIN_CLK_PERIOD_NS)
`define ALIN_WIN_W          24
`define ALIN_WAKE_THR_DEF   15'h0037

`endif

// [shared/alin_pkg.sv]
/*
  Types of the angle linearizer: load sequencer states and the packed state
  record of the top module. Assumes alin_defs.svh is on the include path.
*/
`include "alin_defs.svh"

package alin_pkg;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_DRAIN,
    ST_RUN
  } alin_state_e;

  typedef logic [`ALIN_NUM_PTS-1:0][`ALIN_COEF_W-1:0] alin_coef_t;

  typedef struct packed {
    alin_state_e                 state;
    logic [`ALIN_NVM_AW-1:0]     ldAddr;
    logic                        nvmRdEn;
    logic [`ALIN_NVM_AW-1:0]     nvmAddr;
    logic                        capValid;
    logic [`ALIN_NVM_AW-1:0]     capAddr;
    alin_coef_t                  coef;
    logic                        linEn;
    logic                        scaleSel;
    logic                        cfgReady;
    logic                        p1Valid;
    logic [`ALIN_ANG_W-1:0]      p1Raw;
    logic [`ALIN_COEF_W-1:0]     p1C0;
    logic [`ALIN_COEF_W-1:0]     p1C1;
    logic [`ALIN_FRAC_W-1:0]     p1Frac;
    logic                        p1En;
    logic                        p1Scale;
    logic                        p2Valid;
    logic [`ALIN_ANG_W-1:0]      p2Raw;
    logic [`ALIN_COEF_W-1:0]     p2Corr;
    logic                        p2En;
    logic                        p2Scale;
    logic                        linValid;
    logic [`ALIN_ANG_W-1:0]      linAngle;
    logic [`ALIN_ANG_W-1:0]      trackAngle;
    logic [`ALIN_ANG_W-1:0]      lastAngle;
    logic [`ALIN_WIN_W-1:0]      winCnt;
    logic                        wakeReq;
    logic [`ALIN_COEF_W-1:0]     userData;
  } alin_state_s;

endpackage

// [design/alin_interp.sv]
/*
  Combinational interpolation of the correction between two neighbouring
  coefficients. Assumes the caller registers inputs and result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alin_defs.svh"

module alin_interp (
  // neighbouring coefficients
  input  wire logic [`ALIN_COEF_W-1:0] coefLo,
  input  wire logic [`ALIN_COEF_W-1:0] coefHi,
  // position between them, 0 at coefLo
  input  wire logic [`ALIN_FRAC_W-1:0] frac,
  // interpolated correction
  output logic      [`ALIN_COEF_W-1:0] corr
);

  logic signed [`ALIN_COEF_W:0]                  diff;
  logic signed [`ALIN_COEF_W+`ALIN_FRAC_W+1:0]   prod;
  logic signed [`ALIN_COEF_W+1:0]                step;
  logic signed [`ALIN_COEF_W+1:0]                sum;

  always_comb begin
    // one extra bit: the difference of two 12-bit codes spans 13 bits
    diff = $signed({coefHi[`ALIN_COEF_W-1], coefHi}) - $signed({coefLo[`ALIN_COEF_W-1], coefLo});
    prod = diff * $signed({1'b0, frac});
    // floor division; the result stays between the two codes, so 12 bits hold it
    step = prod[`ALIN_COEF_W+`ALIN_FRAC_W+1:`ALIN_FRAC_W];
    sum  = $signed({{2{coefLo[`ALIN_COEF_W-1]}}, coefLo}) + step;
    corr = sum[`ALIN_COEF_W-1:0];
  end

endmodule

`default_nettype wire

// [test/alin_nvm_model.sv]
/*
  Storage model behind the angle linearizer load port.
  Assumes the bench fills mem while the block is held in reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alin_defs.svh"
module alin_nvm_model (
  // clock
  input  wire logic                    clk,
  // read port
  input  wire logic                    nvmRdEn,
  input  wire logic [`ALIN_NVM_AW-1:0] nvmAddr,
  output logic      [`ALIN_NVM_DW-1:0] nvmData
);
  logic [`ALIN_NVM_DW-1:0] mem [0:32];
  initial nvmData = '0;
  // unselected cycles flip the bus so a stale word never passes for a fresh one
  always @(posedge clk) nvmData <= (nvmRdEn && nvmAddr <= 6'h20) ? mem[nvmAddr] : ~nvmData;
endmodule
`default_nettype wire

// [test/alin_checker.sv]
/*
  Port assertions of angle_linearizer.
  Assumes the bind below; single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alin_defs.svh"
module alin_checker (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [`ALIN_ANG_W-1:0]  rawAngle,
  input wire logic                    rawValid,
  input wire logic                    nvmRdEn,
  input wire logic [`ALIN_NVM_AW-1:0] nvmAddr,
  input wire logic [`ALIN_ANG_W-1:0]  linAngle,
  input wire logic                    linValid,
  input wire logic                    cfgReady,
  input wire logic                    linEnable,
  input wire logic                    lowPower,
  input wire logic [`ALIN_ANG_W-1:0]  trackAngle,
  input wire logic                    wakeReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  lat_fixed_a: assert property (rawValid && cfgReady |-> ##3 linValid)
    else $error("result not three cycles after sample");
  no_early_a: assert property (linValid |-> $past(cfgReady, 3))
    else $error("result before load finished");
  raw_bypass_a: assert property (rawValid && cfgReady && !linEnable |-> ##3 linAngle == $past(rawAngle, 3))
    else $error("disabled path altered the angle");
  track_raw_a: assert property (rawValid && cfgReady |=> trackAngle == $past(rawAngle))
    else $error("tracking angle not the raw angle");
  wake_pulse_a: assert property (wakeReq |-> $past(lowPower) && !$past(wakeReq))
    else $error("wake pulse outside low power or too long");
  load_start_a: assert property ($fell(rst) |=> nvmRdEn && nvmAddr == 6'h00)
    else $error("load did not start at word zero");
  load_order_a: assert property (nvmRdEn && nvmAddr < 6'h20 |=> nvmRdEn && nvmAddr == $past(nvmAddr) + 6'h01)
    else $error("load words out of order");
  ready_time_a: assert property ($rose(cfgReady) |-> $past(nvmRdEn, 3) && $past(nvmAddr, 3) == 6'h20)
    else $error("ready not three cycles after config read");
  ready_hold_a: assert property (cfgReady |=> cfgReady)
    else $error("ready dropped without reset");
  lin_seen_c: cover property (linValid && linEnable);
  wake_seen_c: cover property (wakeReq);
  ready_seen_c: cover property ($rose(cfgReady));
endmodule
bind angle_linearizer alin_checker chk (.clk(clk), .rst(rst), .rawAngle(rawAngle), .rawValid(rawValid),
  .nvmRdEn(nvmRdEn), .nvmAddr(nvmAddr), .linAngle(linAngle), .linValid(linValid), .cfgReady(cfgReady),
  .linEnable(linEnable), .lowPower(lowPower), .trackAngle(trackAngle), .wakeReq(wakeReq));
`default_nettype wire

// [test/testbench.sv]
/*
  Self-checking bench of angle_linearizer with a storage model.
  Assumes a short wake window so windows fit the run.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alin_defs.svh"
module testbench;
  logic        clk = 0, rst = 1, rawValid = 0, lowPower = 0;
  logic [14:0] rawAngle = '0, wakeThresh = 15'h0037, linAngle, trackAngle;
  logic [4:0]  userAddr = '0, prevAddr = '0;
  logic [11:0] nvmData, userData;
  logic [5:0]  nvmAddr;
  logic        nvmRdEn, linValid, cfgReady, linEnable, scaleOut, wakeReq;
  logic [1:0]  cfg;
  logic [14:0] expQ [$];
  logic [14:0] corner [8] = '{15'h0000, 15'h0200, 15'h03FF, 15'h0400, 15'h4000, 15'h7C00, 15'h7E00, 15'h7FFF};
  int          failures = 0, checked = 0, cycles = 0, wakes = 0;
  always #25 clk = ~clk;
  angle_linearizer #(.WAKE_WIN_CYC(24'h000010)) dut (.clk(clk), .rst(rst), .rawAngle(rawAngle),
    .rawValid(rawValid), .nvmRdEn(nvmRdEn), .nvmAddr(nvmAddr), .nvmData(nvmData), .linAngle(linAngle),
    .linValid(linValid), .cfgReady(cfgReady), .linEnable(linEnable), .correctionScaleSelect(scaleOut),
    .lowPower(lowPower), .wakeThresh(wakeThresh), .trackAngle(trackAngle), .wakeReq(wakeReq),
    .userAddr(userAddr), .userData(userData));
  alin_nvm_model nvm (.clk(clk), .nvmRdEn(nvmRdEn), .nvmAddr(nvmAddr), .nvmData(nvmData));
  function automatic logic [14:0] expAng(logic [14:0] raw);
    int c0, c1, c;
    c0 = $signed(nvm.mem[raw[14:10]]);
    c1 = $signed(nvm.mem[5'(raw[14:10] + 5'h01)]);
    c = c0 + (((c1 - c0) * int'(raw[9:0])) >>> 10);
    if (cfg[1]) c = 2 * c;
    return cfg[0] ? 15'(int'(raw) - c) : raw;
  endfunction
  task chk(string name, logic [14:0] seen, logic [14:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task end_of_test();
    $display("checked %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      end_of_test();
    end
    if (!rst && cfgReady) begin
      if (rawValid) expQ.push_back(expAng(rawAngle));
      chk("userData", 15'(userData), 15'(nvm.mem[prevAddr]));
    end
    if (linValid) chk("linAngle", linAngle, expQ.pop_front());
    if (wakeReq) wakes++;
    prevAddr = userAddr;
  end
  // samples offered during the load must be dropped, so valid stays up
  task start();
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    for (int k = 0; k < 32; k++) nvm.mem[k] = 12'($urandom);
    nvm.mem[0] = 12'h800;
    nvm.mem[1] = 12'h7FF;
    nvm.mem[31] = 12'h7FF;
    nvm.mem[32] = {10'($urandom), cfg};
    repeat (3) @(posedge clk);
    rst <= 0;
    rawValid <= 1;
    for (int t = 0; t < 60 && cfgReady !== 1'b1; t++) @(posedge clk);
    chk("cfgReady", 15'(cfgReady), 15'h0001);
  endtask
  task wake(int step, logic [14:0] thr, logic exp);
    wakes = 0;
    wakeThresh <= thr;
    lowPower <= 1;
    rawValid <= 1;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      rawAngle <= rawAngle + 15'(step);
    end
    lowPower <= 0;
    rawValid <= 0;
    repeat (5) @(posedge clk);
    chk("wakeSeen", 15'(wakes != 0), 15'(exp));
    $display("test wake step %0d limit %h done", step, thr);
  endtask
  initial begin
    void'($urandom(32'h6680));
    for (int m = 0; m < 4; m++) begin
      cfg = 2'(m);
      start();
      chk("linEnable", 15'(linEnable), 15'(cfg[0]));
      chk("scaleSelect", 15'(scaleOut), 15'(cfg[1]));
      for (int i = 0; i < 40; i++) begin
        @(posedge clk);
        // corners always taken; gaps only in the random stretch
        rawValid <= (i < 8 || i % 5 != 4);
        rawAngle <= i < 8 ? corner[i] : 15'($urandom);
        userAddr <= 5'($urandom);
      end
      @(posedge clk);
      rawValid <= 0;
      repeat (5) @(posedge clk);
      $display("test mode %0d done", m);
    end
    wake(4, 15'h0037, 1'b1);
    wake(3, 15'h0037, 1'b0);
    wake(3, 15'h0020, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
